// File: logic/plc_map.vh
// register offsets, field positions, reset values and timing counts of the loop control block
`ifndef PLC_MAP_VH
`define PLC_MAP_VH

// register byte offsets
`define PLC_OFS_CTRL 8'h00
`define PLC_OFS_BW 8'h04
`define PLC_OFS_BRK 8'h08

// loop_control_reg fields
`define PLC_CTRL_IE 7
`define PLC_CTRL_FLAG 6
`define PLC_CTRL_PWR 5
`define PLC_CTRL_SEL 4
`define PLC_CTRL_UNUSED 4'hf

// loop_bandwidth_reg fields
`define PLC_BW_AUTO 7
`define PLC_BW_SYNC 6
`define PLC_BW_TRACK 5
`define PLC_BW_XLOSS 4

// break_flag_control_reg fields
`define PLC_BRK_CLR_EN 7

// reset values
`define PLC_RST_IE 1'b0
`define PLC_RST_PWR 1'b1
`define PLC_RST_SEL 1'b0
`define PLC_RST_AUTO 1'b0
`define PLC_RST_ACQ 1'b0
`define PLC_RST_CLR_EN 1'b0

// clock switch stasis, in cycles of each source clock
`define PLC_XTAL_SWITCH_CYC 2'h3
`define PLC_VCO_SWITCH_CYC 2'h3

`endif

// File: logic/plc_lock_flag.v
// lock-change flag: in-sync edge detector with a sticky flag
`timescale 1ns/1ps
module plc_lock_flag (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// loop status
	input wire auto_mode,
	input wire in_sync,
	// software access
	input wire clr_req,
	// flag out
	output reg flag_ff,
	output reg sync_ff
);

reg nxt_flag;
wire change;

// edges only count in automatic mode; in manual mode the indicator has no meaning
assign change = auto_mode & (in_sync ^ sync_ff);

////////////////////////////////////////////////////////////////////////////////
// set wins over clear so an edge in the clearing cycle is never lost
always @* begin
	nxt_flag = flag_ff;
	if (clr_req) begin
		nxt_flag = 1'b0;
	end
	if (change) begin
		nxt_flag = 1'b1;
	end
end

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		flag_ff <= 1'b0;
		sync_ff <= 1'b0;
	end else begin
		flag_ff <= nxt_flag;
		sync_ff <= in_sync;
	end
end

endmodule

// File: logic/plc_clk_switch.v
// base clock selector: holds the output static while the source changes
`timescale 1ns/1ps
`include "plc_map.vh"
module plc_clk_switch (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// requests
	input wire sel_vco,
	input wire vco_tick,
	input wire stop_mode,
	// state
	output reg src_vco_ff,
	output reg hold_ff
);

localparam ST_IDLE = 3'b001;
localparam ST_XTAL = 3'b010;
localparam ST_VCO = 3'b100;

reg [2:0] state_ff;
reg [2:0] nxt_state;
reg [1:0] cnt_ff;
reg [1:0] nxt_cnt;
reg nxt_src;
reg nxt_hold;

////////////////////////////////////////////////////////////////////////////////
// three crystal cycles, then three loop cycles, output frozen throughout
always @* begin
	nxt_state = state_ff;
	nxt_cnt = cnt_ff;
	nxt_src = src_vco_ff;
	nxt_hold = hold_ff;
	case (state_ff)
	ST_IDLE: begin
		if (sel_vco != src_vco_ff) begin
			nxt_state = ST_XTAL;
			nxt_cnt = 2'h0;
			nxt_hold = 1'b1;
		end
	end
	ST_XTAL: begin
		nxt_cnt = cnt_ff + 2'h1;
		if (cnt_ff == `PLC_XTAL_SWITCH_CYC - 2'h1) begin
			nxt_state = ST_VCO;
			nxt_cnt = 2'h0;
		end
	end
	ST_VCO: begin
		if (vco_tick) begin
			nxt_cnt = cnt_ff + 2'h1;
			if (cnt_ff == `PLC_VCO_SWITCH_CYC - 2'h1) begin
				nxt_state = ST_IDLE;
				nxt_src = sel_vco;
				nxt_hold = 1'b0;
			end
		end
	end
	default: begin
		nxt_state = ST_IDLE;
		nxt_hold = 1'b0;
	end
	endcase
	// the loop oscillator may already be dead in stop, so fall back at once
	if (stop_mode) begin
		nxt_state = ST_IDLE;
		nxt_src = 1'b0;
		nxt_hold = 1'b0;
	end
end

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		state_ff <= ST_IDLE;
		cnt_ff <= 2'h0;
		src_vco_ff <= 1'b0;
		hold_ff <= 1'b0;
	end else begin
		state_ff <= nxt_state;
		cnt_ff <= nxt_cnt;
		src_vco_ff <= nxt_src;
		hold_ff <= nxt_hold;
	end
end

endmodule

// File: logic/plc_top.v
// loop lock interrupt, base clock select and low-power control with an AHB-Lite register port
`timescale 1ns/1ps
`include "plc_map.vh"
module plc_top (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// loop status
	input wire loop_in_sync,
	input wire loop_tracking,
	input wire crystal_lost,
	input wire vco_tick,
	// system state
	input wire stop_mode,
	input wire wait_mode,
	input wire break_active,
	// clock generator controls
	output reg clock_gen_irq,
	output reg clock_gen_en,
	output reg crystal_clock_en,
	output reg base_clock_output_en,
	output reg base_src_vco,
	output reg base_clock_hold,
	output reg loop_power_on,
	output reg auto_mode,
	output reg manual_tracking
);

// software-held control state
reg lock_irq_enable_ff;
reg loop_power_on_ff;
reg base_clock_source_select_ff;
reg auto_ff;
reg acq_manual_ff;
reg break_clear_enable_ff;
reg nxt_ie;
reg nxt_pwr;
reg nxt_sel;

// bus pipeline
reg wr_pend_ff;
reg [7:0] wr_addr_ff;
reg [31:0] nxt_rdata;

// status from the leaf modules
wire lock_change_flag;
wire src_vco;
wire hold;

// delayed copy of stop, keeps the base clock output off one cycle past stop
reg stop_q_ff;

wire addr_phase;
wire rd_take;
wire wr_ctrl;
wire wr_bw;
wire wr_brk;
wire ctrl_access;
wire flag_protected;
wire flag_clr;
wire flag_vis;

////////////////////////////////////////////////////////////////////////////////
// helpers

// register decode shared by read and write paths
function is_reg;
	input [7:0] a;
	input [7:0] ofs;
	begin
		is_reg = (a == ofs);
	end
endfunction

// byte offset of the word, low bits ignored since only whole words are moved
function [7:0] word_ofs;
	input [31:0] a;
	begin
		word_ofs = {a[7:2], 2'b00};
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// ahb address and data phases

// a transfer is taken when selected, the bus is ready and htrans is nonseq or seq
assign addr_phase = hsel & hready & htrans[1];
assign rd_take = addr_phase & ~hwrite;
assign wr_ctrl = wr_pend_ff & is_reg(wr_addr_ff, `PLC_OFS_CTRL);
assign wr_bw = wr_pend_ff & is_reg(wr_addr_ff, `PLC_OFS_BW);
assign wr_brk = wr_pend_ff & is_reg(wr_addr_ff, `PLC_OFS_BRK);

// a read or the write half of a read-modify-write both touch the control register
assign ctrl_access = (rd_take & is_reg(word_ofs(haddr), `PLC_OFS_CTRL)) | wr_ctrl;

// in break the flag is only clearable when break clear is enabled
assign flag_protected = break_active & ~break_clear_enable_ff;
assign flag_clr = ctrl_access & ~flag_protected;

// manual mode hides the flag from software
assign flag_vis = lock_change_flag & auto_ff;

// write side of the bus: address captured now, data taken next cycle
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		wr_pend_ff <= 1'b0;
		wr_addr_ff <= 8'h00;
	end else begin
		wr_pend_ff <= addr_phase & hwrite;
		if (addr_phase) begin
			wr_addr_ff <= word_ofs(haddr);
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// read mux, sampled at the address phase so no wait state is needed

always @* begin
	nxt_rdata = 32'h0000_0000;
	case (word_ofs(haddr))
	`PLC_OFS_CTRL: begin
		nxt_rdata[`PLC_CTRL_IE] = lock_irq_enable_ff & auto_ff;
		nxt_rdata[`PLC_CTRL_FLAG] = flag_vis;
		nxt_rdata[`PLC_CTRL_PWR] = loop_power_on_ff;
		nxt_rdata[`PLC_CTRL_SEL] = base_clock_source_select_ff;
		nxt_rdata[3:0] = `PLC_CTRL_UNUSED;
	end
	`PLC_OFS_BW: begin
		nxt_rdata[`PLC_BW_AUTO] = auto_ff;
		nxt_rdata[`PLC_BW_SYNC] = loop_in_sync & auto_ff;
		nxt_rdata[`PLC_BW_TRACK] = auto_ff ? loop_tracking : acq_manual_ff;
		nxt_rdata[`PLC_BW_XLOSS] = crystal_lost & base_clock_source_select_ff;
	end
	`PLC_OFS_BRK: begin
		nxt_rdata[`PLC_BRK_CLR_EN] = break_clear_enable_ff;
	end
	default: begin
		nxt_rdata = 32'h0000_0000; // unmapped reads return zero
	end
	endcase
end

// response is always okay with zero wait states
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		hrdata <= 32'h0000_0000;
		hreadyout <= 1'b1;
		hresp <= 1'b0;
	end else begin
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		if (rd_take) begin
			hrdata <= nxt_rdata;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// control register with the power/select interlock

// interlock checks the held bits, so enabling the loop clock from off takes two writes
always @* begin
	nxt_ie = lock_irq_enable_ff;
	nxt_pwr = loop_power_on_ff;
	nxt_sel = base_clock_source_select_ff;
	if (wr_ctrl) begin
		if (auto_ff) begin
			nxt_ie = hwdata[`PLC_CTRL_IE];
		end
		if (hwdata[`PLC_CTRL_PWR] | ~base_clock_source_select_ff) begin
			nxt_pwr = hwdata[`PLC_CTRL_PWR];
		end
		// lock is not checked: software owns that decision
		if (~hwdata[`PLC_CTRL_SEL] | loop_power_on_ff) begin
			nxt_sel = hwdata[`PLC_CTRL_SEL];
		end
	end
	// entering stop forces the crystal back in and keeps it after recovery
	if (stop_mode) begin
		nxt_sel = 1'b0;
	end
end

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		lock_irq_enable_ff <= `PLC_RST_IE;
		loop_power_on_ff <= `PLC_RST_PWR;
		base_clock_source_select_ff <= `PLC_RST_SEL;
	end else begin
		lock_irq_enable_ff <= nxt_ie;
		loop_power_on_ff <= nxt_pwr;
		base_clock_source_select_ff <= nxt_sel;
	end
end

////////////////////////////////////////////////////////////////////////////////
// bandwidth and break flag control registers

// the manual acquisition bit is only writable in manual mode and survives auto mode
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		auto_ff <= `PLC_RST_AUTO;
		acq_manual_ff <= `PLC_RST_ACQ;
		break_clear_enable_ff <= `PLC_RST_CLR_EN;
	end else begin
		if (wr_bw) begin
			auto_ff <= hwdata[`PLC_BW_AUTO];
			if (!auto_ff) begin
				acq_manual_ff <= hwdata[`PLC_BW_TRACK];
			end
		end
		if (wr_brk) begin
			break_clear_enable_ff <= hwdata[`PLC_BRK_CLR_EN];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// leaf modules

plc_lock_flag i_plc_lock_flag (
	.hclk(hclk),
	.hresetn(hresetn),
	.auto_mode(auto_ff),
	.in_sync(loop_in_sync),
	.clr_req(flag_clr),
	.flag_ff(lock_change_flag),
	.sync_ff()
);

plc_clk_switch i_plc_clk_switch (
	.hclk(hclk),
	.hresetn(hresetn),
	.sel_vco(base_clock_source_select_ff),
	.vco_tick(vco_tick),
	.stop_mode(stop_mode),
	.src_vco_ff(src_vco),
	.hold_ff(hold)
);

////////////////////////////////////////////////////////////////////////////////
// outputs to the generator and the core

// wait mode changes nothing here: the generator keeps running and may still interrupt
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		stop_q_ff <= 1'b0;
		clock_gen_irq <= 1'b0;
		clock_gen_en <= 1'b1;
		crystal_clock_en <= 1'b1;
		base_clock_output_en <= 1'b1;
		base_src_vco <= 1'b0;
		base_clock_hold <= 1'b0;
		loop_power_on <= `PLC_RST_PWR;
		auto_mode <= `PLC_RST_AUTO;
		manual_tracking <= `PLC_RST_ACQ;
	end else begin
		stop_q_ff <= stop_mode;
		// level request, dropped one cycle after the flag clears, or at the first edge in stop
		clock_gen_irq <= flag_vis & lock_irq_enable_ff & ~stop_mode;
		clock_gen_en <= ~stop_mode;
		crystal_clock_en <= ~stop_mode;
		base_clock_output_en <= ~stop_mode & ~stop_q_ff;
		base_src_vco <= src_vco;
		base_clock_hold <= hold;
		loop_power_on <= loop_power_on_ff;
		auto_mode <= auto_ff;
		manual_tracking <= acq_manual_ff;
	end
end

endmodule

// File: tb/plc_props_properties.sv
// concurrent checks on the loop control block ports
`timescale 1ns/1ps
module plc_props (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// bus address phase
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	// loop and system state
	input wire loop_in_sync,
	input wire stop_mode,
	input wire break_active,
	// clock generator controls
	input wire clock_gen_irq,
	input wire clock_gen_en,
	input wire crystal_clock_en,
	input wire base_clock_output_en,
	input wire base_src_vco,
	input wire base_clock_hold,
	input wire loop_power_on,
	input wire auto_mode
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////////////////////
	// request edges trace back to an in-sync change two edges earlier
	property p_irq_cause; $rose(clock_gen_irq) |-> $past(loop_in_sync, 2) != $past(loop_in_sync, 3); endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("request rose without a lock change");
	// manual mode never lets a request out
	property p_irq_auto; clock_gen_irq |-> auto_mode; endproperty
	a_irq_auto: assert property (p_irq_auto) else $error("request while in manual mode");
	// a control read outside break drops the request within three edges
	property p_rd_clear; hsel && hready && htrans[1] && !hwrite && haddr[7:2] == 6'h0 && !break_active
		&& $stable(loop_in_sync) |-> ##[1:3] !clock_gen_irq; endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("control read kept the request");
	// stop silences the generator, crystal and base clock output enables and the request
	property p_stop_off; stop_mode |=> !clock_gen_en && !crystal_clock_en && !base_clock_output_en && !clock_gen_irq;
	endproperty
	a_stop_off: assert property (p_stop_off) else $error("generator output alive in stop");
	// stop falls back to the crystal; the source output trails the selector by one register
	property p_stop_src; stop_mode ##1 stop_mode ##1 stop_mode |-> !base_src_vco; endproperty
	a_stop_src: assert property (p_stop_src) else $error("loop clock still in use in stop");
	// leaving stop keeps the crystal source
	property p_stop_exit; $fell(stop_mode) |-> !base_src_vco [*3]; endproperty
	a_stop_exit: assert property (p_stop_exit) else $error("loop clock after stop");
	// the loop clock is never in use with loop power off
	property p_pwr_lock; base_src_vco |-> loop_power_on; endproperty
	a_pwr_lock: assert property (p_pwr_lock) else $error("loop source with power off");
	// a switch holds the output for the three crystal cycles at least
	property p_hold_min; $rose(base_clock_hold) && !stop_mode |-> base_clock_hold [*3]; endproperty
	a_hold_min: assert property (p_hold_min) else $error("hold shorter than three cycles");
	// and the hold ends once the loop ticks are counted
	property p_hold_max; base_clock_hold |-> ##[1:20] !base_clock_hold; endproperty
	a_hold_max: assert property (p_hold_max) else $error("hold never released");
	c_irq: cover property ($rose(clock_gen_irq));
	c_hold: cover property ($rose(base_clock_hold));
	c_stop: cover property ($rose(stop_mode) ##1 !clock_gen_en);
endmodule

// File: tb/plc_loop_model.sv
// loop stand-in: lock indicator follows the command after an acquisition delay
`timescale 1ns/1ps
module plc_loop_model (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// command from the bench
	input wire lock_cmd,
	// loop status
	output wire loop_in_sync,
	output wire loop_tracking,
	output reg vco_tick
);
	reg [2:0] sync_ff;
	// tracking comes one cycle before lock, as acquisition ends first
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_ff <= 3'h0;
			vco_tick <= 1'b0;
		end else begin
			sync_ff <= {sync_ff[1:0], lock_cmd};
			vco_tick <= ~vco_tick; // loop clock at half rate
		end
	end
	assign loop_tracking = sync_ff[1];
	assign loop_in_sync = sync_ff[2];
endmodule

// File: tb/test_pll_lock_irq_lowpower_ctrl.sv
// directed bench for the loop control block over its register bus
`timescale 1ns/1ps
`include "plc_map.vh"
module test_pll_lock_irq_lowpower_ctrl;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, lock_cmd = 0, stop_mode = 0, break_active = 0;
	logic wait_mode = 0, crystal_lost = 0;
	logic [31:0] haddr = 0, hwdata = 0;
	logic [1:0] htrans = 0;
	wire [31:0] hrdata;
	wire hreadyout, hresp, loop_in_sync, loop_tracking, vco_tick, clock_gen_irq, clock_gen_en, crystal_clock_en;
	wire base_clock_output_en, base_src_vco, base_clock_hold, loop_power_on, auto_mode, manual_tracking;
	int error_cnt = 0, comparisons = 0;
	plc_top i_plc_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .loop_in_sync, .loop_tracking, .crystal_lost, .vco_tick, .stop_mode,
		.wait_mode, .break_active, .clock_gen_irq, .clock_gen_en, .crystal_clock_en, .base_clock_output_en,
		.base_src_vco, .base_clock_hold, .loop_power_on, .auto_mode, .manual_tracking);
	plc_loop_model i_plc_loop_model (.hclk, .hresetn, .lock_cmd, .loop_in_sync, .loop_tracking, .vco_tick);
	////////////////////////////////////////////////////////////////////////////////
	// 50 MHz clock
	initial begin
		forever #10 hclk = ~hclk;
	end
	task wrap_up();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait for hready at a rising edge; a hang ends the run
	task hwait();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: bus hang", $time);
			wrap_up();
		end
	endtask
	// one single word transfer: address phase, then data phase
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		hwait();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		hwait();
		rd = hrdata;
		// the slave never answers with an error
		if (hresp !== 1'b0) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: error response", $time);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] d;
		xfer(1'b1, a, v, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		xfer(1'b0, a, 32'h0000_0000, d);
		chk(d, e);
	endtask
	// move the loop and let flag and request land
	task setlock(input logic v);
		int n;
		@(posedge hclk);
		lock_cmd <= v;
		n = 0;
		while (loop_in_sync !== v && n < 64) begin
			@(posedge hclk);
			n++;
		end
		chk({31'h0, loop_in_sync}, {31'h0, v});
		repeat (3) @(posedge hclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		int n;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rd(`PLC_OFS_CTRL, 32'h0000_002f);
		rd(`PLC_OFS_BW, 32'h0000_0000);
		rd(`PLC_OFS_BRK, 32'h0000_0000);
		rd(8'h0c, 32'h0000_0000);
		wr(`PLC_OFS_CTRL, 32'h0000_00a0);
		rd(`PLC_OFS_CTRL, 32'h0000_002f);
		wr(`PLC_OFS_BW, 32'h0000_0080);
		wr(`PLC_OFS_CTRL, 32'h0000_00a0);
		rd(`PLC_OFS_CTRL, 32'h0000_00af);
		setlock(1'b1);
		chk({31'h0, clock_gen_irq}, 32'h0000_0001);
		rd(`PLC_OFS_BW, 32'h0000_00e0);
		rd(`PLC_OFS_CTRL, 32'h0000_00ef);
		rd(`PLC_OFS_CTRL, 32'h0000_00af);
		chk({31'h0, clock_gen_irq}, 32'h0000_0000);
		wr(`PLC_OFS_CTRL, 32'h0000_0020);
		setlock(1'b0);
		chk({31'h0, clock_gen_irq}, 32'h0000_0000);
		rd(`PLC_OFS_CTRL, 32'h0000_006f);
		// break with flag protection, then with clearing allowed
		setlock(1'b1);
		break_active <= 1'b1;
		rd(`PLC_OFS_CTRL, 32'h0000_006f);
		rd(`PLC_OFS_CTRL, 32'h0000_006f);
		wr(`PLC_OFS_BRK, 32'h0000_0080);
		rd(`PLC_OFS_CTRL, 32'h0000_006f);
		rd(`PLC_OFS_CTRL, 32'h0000_002f);
		break_active <= 1'b0;
		rd(`PLC_OFS_CTRL, 32'h0000_002f);
		// wait mode keeps the generator running and the request path live
		wait_mode <= 1'b1;
		wr(`PLC_OFS_CTRL, 32'h0000_00a0);
		setlock(1'b0);
		chk({30'h0, clock_gen_en, clock_gen_irq}, 32'h0000_0003);
		rd(`PLC_OFS_CTRL, 32'h0000_00ef);
		wr(`PLC_OFS_CTRL, 32'h0000_0020);
		wait_mode <= 1'b0;
		setlock(1'b1);
		// loop selected while unlocked, skipping the lock check on purpose
		setlock(1'b0);
		rd(`PLC_OFS_CTRL, 32'h0000_006f);
		wr(`PLC_OFS_CTRL, 32'h0000_0030);
		for (n = 0; n < 64 && base_src_vco !== 1'b1; n++) @(posedge hclk);
		chk({31'h0, base_src_vco}, 32'h0000_0001);
		rd(`PLC_OFS_CTRL, 32'h0000_003f);
		// crystal loss shows only while the loop is selected as the base clock source
		crystal_lost <= 1'b1;
		rd(`PLC_OFS_BW, 32'h0000_0090);
		crystal_lost <= 1'b0;
		wr(`PLC_OFS_CTRL, 32'h0000_0010);
		rd(`PLC_OFS_CTRL, 32'h0000_003f);
		stop_mode <= 1'b1;
		repeat (4) @(posedge hclk);
		chk({27'h0, clock_gen_en, crystal_clock_en, base_clock_output_en, base_src_vco, clock_gen_irq}, 32'h0);
		stop_mode <= 1'b0;
		repeat (3) @(posedge hclk);
		chk({27'h0, clock_gen_en, crystal_clock_en, base_clock_output_en, base_src_vco, clock_gen_irq}, 32'h1c);
		rd(`PLC_OFS_CTRL, 32'h0000_002f);
		wr(`PLC_OFS_CTRL, 32'h0000_0000);
		rd(`PLC_OFS_CTRL, 32'h0000_000f);
		chk({31'h0, loop_power_on}, 32'h0000_0000);
		wr(`PLC_OFS_CTRL, 32'h0000_0030);
		rd(`PLC_OFS_CTRL, 32'h0000_002f);
		wr(`PLC_OFS_BW, 32'h0000_0000);
		setlock(1'b1);
		rd(`PLC_OFS_CTRL, 32'h0000_002f);
		chk({31'h0, clock_gen_irq}, 32'h0000_0000);
		// manual tracking bit survives a spell of automatic mode
		wr(`PLC_OFS_BW, 32'h0000_0020);
		rd(`PLC_OFS_BW, 32'h0000_0020);
		wr(`PLC_OFS_BW, 32'h0000_00a0);
		rd(`PLC_OFS_BW, 32'h0000_00e0);
		// lock confirmed above, so the loop clock is selected the recommended way
		wr(`PLC_OFS_CTRL, 32'h0000_0030);
		rd(`PLC_OFS_CTRL, 32'h0000_003f);
		wr(`PLC_OFS_BW, 32'h0000_0000);
		rd(`PLC_OFS_BW, 32'h0000_0020);
		chk({30'h0, manual_tracking, auto_mode}, 32'h0000_0002);
		wrap_up();
	end
endmodule
bind plc_top plc_props i_plc_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .loop_in_sync,
	.stop_mode, .break_active, .clock_gen_irq, .clock_gen_en, .crystal_clock_en, .base_clock_output_en,
	.base_src_vco, .base_clock_hold, .loop_power_on, .auto_mode);
